/* rtl/dmo_monitor_map.sv */
// Behaviour
// - Motor speed value comes from the drive register, unfiltered, raw unless UNIT_DECI or UNIT_WHOLE is selected.
// - Motor speed is scaled by the display unit parameter.
// - Unsupported control mode makes motor speed read zero.
// - Motor speed is read-only 16-bit on subindex 1.
// - Bus voltage in 1 V on subindex 1; subindex 2 reads 0x0046.
// - Analog levels in 0.1 % steps; 10 V reads 100 %.
// - First analog: subindex 2 reads 0x004E, subindex 1 its level.
// - Second analog: subindex 2 reads 0x004F, subindex 1 its level.
// - Third analog: subindex 2 reads 0x0050, subindex 1 its level.
// - Terminal word on subindex 1; subindex 2 reads 0x0049.
// - Crash record kept in nonvolatile store, readable by the master; the code holds it in rec_r, which reset clears to zero.
// - Writing 0xFB to crash object subindex 0 erases the record.
// - Read-only 16-bit crash count increments on each new event, holding at 0xFFFF.
// - Bus voltage object is a read-only monitor entry.
`timescale 1ns/1ns
module dmo_monitor_map
  import dmo_pkg::*;
(
  // Clock and reset
  input  wire logic        CLOCK_I,
  input  wire logic        RST_N_I,
  // Object access request
  input  wire logic        REQ_I,
  input  wire logic        WR_I,
  input  wire logic [15:0] INDEX_I,
  input  wire logic [7:0]  SUB_I,
  input  wire logic [15:0] WDATA_I,
  // Object access answer
  output logic             ACK_O,
  output logic             ABORT_O,
  output logic [15:0]      RDATA_O,
  // Drive monitor values
  input  wire logic [15:0] SPEED_RAW_I,
  input  wire logic        SPEED_OK_I,
  input  wire logic [3:0]  DISP_UNIT_I,
  input  wire logic [15:0] BUS_VOLT_I,
  input  wire logic [15:0] AN1_MV_I,
  input  wire logic [15:0] AN2_MV_I,
  input  wire logic [15:0] AN3_MV_I,
  input  wire logic [15:0] TERM_WORD_I,
  // Crash events and nonvolatile store
  input  wire logic        CRASH_I,
  input  wire logic [15:0] CRASH_CODE_I,
  output logic             STORE_ERASE_O
);
  import dmo_pkg::*;

  function automatic logic is_monitor(input logic [15:0] idx);
    return (idx == IDX_SPEED) || (idx == IDX_BUS) || (idx == IDX_AN1)
        || (idx == IDX_AN2) || (idx == IDX_AN3) || (idx == IDX_TERM);
  endfunction

  logic [15:0]       rec_r [REC_DEPTH];
  logic [REC_AW-1:0] wptr_r;
  logic [15:0]       count_r;
  logic [15:0]       count_nxt;
  logic              ack_r;
  logic              abort_r;
  logic [15:0]       rdata_r;
  logic              erase_r;

  // Analog level scaling
  logic [15:0] an_mv  [AN_NUM];
  logic [15:0] an_lvl [AN_NUM];
  assign an_mv[0] = AN1_MV_I;
  assign an_mv[1] = AN2_MV_I;
  assign an_mv[2] = AN3_MV_I;
  genvar g;
  generate
    for (g = 0; g < AN_NUM; g++)
    begin : g_an
      assign an_lvl[g] = an_mv[g] / AN_DIV;
    end
  endgenerate

  // Motor speed in the selected unit
  wire [15:0] speed_scaled =
    (DISP_UNIT_I == UNIT_DECI)  ? SPEED_RAW_I / DIV_DECI :
    (DISP_UNIT_I == UNIT_WHOLE) ? SPEED_RAW_I / DIV_WHOLE :
    SPEED_RAW_I;
  wire [15:0] speed_val = SPEED_OK_I ? speed_scaled : ZERO_WORD;

  // Monitor value and source selection
  wire [15:0] mon_val =
    (INDEX_I == IDX_SPEED) ? speed_val :
    (INDEX_I == IDX_BUS)   ? BUS_VOLT_I :
    (INDEX_I == IDX_AN1)   ? an_lvl[0] :
    (INDEX_I == IDX_AN2)   ? an_lvl[1] :
    (INDEX_I == IDX_AN3)   ? an_lvl[2] :
    TERM_WORD_I;
  wire [15:0] mon_src =
    (INDEX_I == IDX_SPEED) ? SRC_SPEED :
    (INDEX_I == IDX_BUS)   ? SRC_BUS :
    (INDEX_I == IDX_AN1)   ? SRC_AN1 :
    (INDEX_I == IDX_AN2)   ? SRC_AN2 :
    (INDEX_I == IDX_AN3)   ? SRC_AN3 :
    SRC_TERM;

  // Access decoding
  wire mon_sel   = is_monitor(INDEX_I);
  wire crash_sel = (INDEX_I == IDX_CRASH);
  wire mon_sub   = (SUB_I <= SUB_SOURCE);
  wire rec_sub   = (SUB_I >= SUB_REC0) && (SUB_I <= SUB_RECN);
  wire crs_sub   = (SUB_I <= SUB_VALUE) || rec_sub;
  wire sub_ok    = (mon_sel && mon_sub) || (crash_sel && crs_sub);
  wire [7:0] rec_off = SUB_I - SUB_REC0;
  wire [REC_AW-1:0] rec_idx = rec_off[REC_AW-1:0];
  wire clear_ok  = WR_I && crash_sel && (SUB_I == SUB_COUNT)
                && (WDATA_I == {8'h00, CLEAR_CODE});
  wire refuse    = !sub_ok || (WR_I && !clear_ok);
  wire clear_cmd = REQ_I && clear_ok;

  wire [15:0] crs_word =
    (SUB_I == SUB_COUNT) ? CRS_ENTRIES :
    (SUB_I == SUB_VALUE) ? count_r :
    rec_r[rec_idx];
  wire [15:0] mon_word =
    (SUB_I == SUB_COUNT) ? MON_ENTRIES :
    (SUB_I == SUB_VALUE) ? mon_val :
    mon_src;
  wire [15:0] rd_word =
    (refuse || WR_I) ? ZERO_WORD :
    crash_sel ? crs_word :
    mon_word;

  // Crash count: clear and event in one cycle give 1, saturates at maximum
  assign count_nxt =
    CRASH_I ? ((clear_cmd) ? 16'h0001 :
               (count_r == COUNT_MAX) ? COUNT_MAX :
               count_r + 16'h0001) :
    clear_cmd ? ZERO_WORD : count_r;

  always_ff @(posedge CLOCK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      ack_r   <= 1'b0;
      abort_r <= 1'b0;
      rdata_r <= ZERO_WORD;
      erase_r <= 1'b0;
    end
    else
    begin
      ack_r   <= REQ_I;
      abort_r <= REQ_I && refuse;
      rdata_r <= REQ_I ? rd_word : ZERO_WORD;
      erase_r <= clear_cmd;
    end
  end

  always_ff @(posedge CLOCK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      count_r <= ZERO_WORD;
    end
    else
    begin
      count_r <= count_nxt;
    end
  end

  // Crash record store, erased by the clear command
  wire [REC_AW-1:0] wptr_inc = wptr_r + 3'h1;
  always_ff @(posedge CLOCK_I or negedge RST_N_I)
  begin
    if (!RST_N_I)
    begin
      wptr_r <= PTR_RESET;
      for (int i = 0; i < REC_DEPTH; i++)
        rec_r[i] <= ZERO_WORD;
    end
    else if (CRASH_I)
    begin
      wptr_r <= clear_cmd ? 3'h1 : wptr_inc;
      for (int i = 0; i < REC_DEPTH; i++)
        if (clear_cmd)
          rec_r[i] <= (i == 0) ? CRASH_CODE_I : ZERO_WORD;
        else if (REC_AW'(i) == wptr_r)
          rec_r[i] <= CRASH_CODE_I;
    end
    else if (clear_cmd)
    begin
      wptr_r <= PTR_RESET;
      for (int i = 0; i < REC_DEPTH; i++)
        rec_r[i] <= ZERO_WORD;
    end
  end

  assign ACK_O         = ack_r;
  assign ABORT_O       = abort_r;
  assign RDATA_O       = rdata_r;
  assign STORE_ERASE_O = erase_r;

  // Checks
  wire [REC_AW-1:0] wptr_prev = wptr_r - 3'h1;
  wire [15:0]       rec_last  = rec_r[wptr_prev];
  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (!RST_N_I);

  sequence s_read(logic [15:0] idx, logic [7:0] sub);
    REQ_I && !WR_I && INDEX_I == idx && SUB_I == sub;
  endsequence
  sequence s_clear;
    REQ_I && WR_I && INDEX_I == IDX_CRASH && SUB_I == SUB_COUNT
      && WDATA_I == {8'h00, CLEAR_CODE};
  endsequence
  sequence s_erase;
    STORE_ERASE_O ##1 (!STORE_ERASE_O || $past(clear_cmd));
  endsequence

  property p_speed_raw;
    s_read(IDX_SPEED, SUB_VALUE) and
      (SPEED_OK_I && DISP_UNIT_I == UNIT_CENTI)
      |=> ACK_O && RDATA_O == $past(SPEED_RAW_I);
  endproperty
  a_speed_raw: assert property (p_speed_raw)
    else $error("speed read not raw");

  property p_speed_deci;
    s_read(IDX_SPEED, SUB_VALUE) and
      (SPEED_OK_I && DISP_UNIT_I == UNIT_DECI)
      |=> RDATA_O == $past(SPEED_RAW_I) / DIV_DECI;
  endproperty
  a_speed_deci: assert property (p_speed_deci)
    else $error("speed unit scaling wrong");

  property p_speed_zero;
    s_read(IDX_SPEED, SUB_VALUE) and !SPEED_OK_I |=> RDATA_O == ZERO_WORD;
  endproperty
  a_speed_zero: assert property (p_speed_zero)
    else $error("unsupported speed not zero");

  property p_ro_refuse;
    REQ_I && WR_I && is_monitor(INDEX_I)
      |=> ACK_O && ABORT_O && $stable(count_r);
  endproperty
  a_ro_refuse: assert property (p_ro_refuse)
    else $error("monitor write not refused");

  property p_bus_src;
    s_read(IDX_BUS, SUB_SOURCE) |=> !ABORT_O && RDATA_O == 16'h0046;
  endproperty
  a_bus_src: assert property (p_bus_src)
    else $error("bus voltage source wrong");

  property p_an1_lvl;
    s_read(IDX_AN1, SUB_VALUE) and AN1_MV_I == 16'h2710
      |=> RDATA_O == 16'h03E8;
  endproperty
  a_an1_lvl: assert property (p_an1_lvl)
    else $error("full scale analog not 100 percent");

  property p_an_src;
    (s_read(IDX_AN1, SUB_SOURCE) |=> RDATA_O == 16'h004E) and
    (s_read(IDX_AN2, SUB_SOURCE) |=> RDATA_O == 16'h004F) and
    (s_read(IDX_AN3, SUB_SOURCE) |=> RDATA_O == 16'h0050);
  endproperty
  a_an_src: assert property (p_an_src)
    else $error("analog source number wrong");

  property p_term;
    (s_read(IDX_TERM, SUB_SOURCE) |=> RDATA_O == 16'h0049) and
    (s_read(IDX_TERM, SUB_VALUE) |=> RDATA_O == $past(TERM_WORD_I));
  endproperty
  a_term: assert property (p_term)
    else $error("terminal object wrong");

  property p_clear;
    s_clear |=> !ABORT_O ##0 s_erase;
  endproperty
  a_clear: assert property (p_clear)
    else $error("clear did not erase");

  property p_count_inc;
    CRASH_I && !clear_cmd && count_r != COUNT_MAX
      |=> count_r == $past(count_r) + 16'h0001;
  endproperty
  a_count_inc: assert property (p_count_inc)
    else $error("crash count not incremented");

  property p_count_sat;
    (CRASH_I && count_r == COUNT_MAX && !clear_cmd |=> count_r == COUNT_MAX)
    and (clear_cmd && !CRASH_I |=> count_r == ZERO_WORD);
  endproperty
  a_count_sat: assert property (p_count_sat)
    else $error("crash count wrapped or not cleared");

  property p_ack_follows;
    REQ_I |=> ACK_O;
  endproperty
  a_ack_follows: assert property (p_ack_follows)
    else $error("request not answered");

  property p_idle_quiet;
    !REQ_I |=> !ACK_O && !ABORT_O && RDATA_O == ZERO_WORD;
  endproperty
  a_idle_quiet: assert property (p_idle_quiet)
    else $error("answer without request");

  property p_speed_whole;
    s_read(IDX_SPEED, SUB_VALUE) and
      (SPEED_OK_I && DISP_UNIT_I == UNIT_WHOLE)
      |=> RDATA_O == $past(SPEED_RAW_I) / DIV_WHOLE;
  endproperty
  a_speed_whole: assert property (p_speed_whole)
    else $error("speed whole unit scaling wrong");

  property p_bus_val;
    s_read(IDX_BUS, SUB_VALUE) |=> RDATA_O == $past(BUS_VOLT_I);
  endproperty
  a_bus_val: assert property (p_bus_val)
    else $error("bus voltage value wrong");

  property p_an_lvl;
    (s_read(IDX_AN1, SUB_VALUE) |=> RDATA_O == $past(AN1_MV_I) / AN_DIV) and
    (s_read(IDX_AN2, SUB_VALUE) |=> RDATA_O == $past(AN2_MV_I) / AN_DIV) and
    (s_read(IDX_AN3, SUB_VALUE) |=> RDATA_O == $past(AN3_MV_I) / AN_DIV);
  endproperty
  a_an_lvl: assert property (p_an_lvl)
    else $error("analog level wrong");

  property p_count_ro;
    REQ_I && WR_I && INDEX_I == IDX_CRASH && SUB_I == SUB_VALUE && !CRASH_I
      |=> ABORT_O && count_r == $past(count_r);
  endproperty
  a_count_ro: assert property (p_count_ro)
    else $error("crash count write not refused");

  property p_rec_write;
    CRASH_I |=> rec_last == $past(CRASH_CODE_I);
  endproperty
  a_rec_write: assert property (p_rec_write)
    else $error("crash code not stored");

  property p_erase_only;
    !clear_cmd |=> !STORE_ERASE_O;
  endproperty
  a_erase_only: assert property (p_erase_only)
    else $error("erase without clear command");

  property p_clear_event;
    clear_cmd && CRASH_I
      |=> count_r == 16'h0001 && rec_r[0] == $past(CRASH_CODE_I);
  endproperty
  a_clear_event: assert property (p_clear_event)
    else $error("event beside clear not kept");

  property p_clear_wipes;
    clear_cmd && !CRASH_I |=> wptr_r == PTR_RESET && rec_r[0] == ZERO_WORD;
  endproperty
  a_clear_wipes: assert property (p_clear_wipes)
    else $error("clear did not wipe record");

endmodule // dmo_monitor_map

/* rtl/dmo_pkg.sv */
package dmo_pkg;
  // Object indexes
  localparam logic [15:0] IDX_SPEED   = 16'h2200;
  localparam logic [15:0] IDX_BUS     = 16'h2210;
  localparam logic [15:0] IDX_AN1     = 16'h2220;
  localparam logic [15:0] IDX_AN2     = 16'h2240;
  localparam logic [15:0] IDX_AN3     = 16'h2260;
  localparam logic [15:0] IDX_TERM    = 16'h2270;
  localparam logic [15:0] IDX_CRASH   = 16'h4000;
  // Constant source register numbers in the drive register space
  localparam logic [15:0] SRC_SPEED   = 16'h0044;
  localparam logic [15:0] SRC_BUS     = 16'h0046;
  localparam logic [15:0] SRC_AN1     = 16'h004E;
  localparam logic [15:0] SRC_AN2     = 16'h004F;
  localparam logic [15:0] SRC_AN3     = 16'h0050;
  localparam logic [15:0] SRC_TERM    = 16'h0049;
  // Subindexes
  localparam logic [7:0]  SUB_COUNT   = 8'h00;
  localparam logic [7:0]  SUB_VALUE   = 8'h01;
  localparam logic [7:0]  SUB_SOURCE  = 8'h02;
  localparam logic [7:0]  SUB_REC0    = 8'h02;
  localparam logic [7:0]  SUB_RECN    = 8'h09;
  // Entry counts read on subindex 0
  localparam logic [15:0] MON_ENTRIES = 16'h0002;
  localparam logic [15:0] CRS_ENTRIES = 16'h0009;
  // Crash record
  localparam logic [7:0]  CLEAR_CODE  = 8'hFB;
  localparam int          REC_DEPTH   = 8;
  localparam int          REC_AW      = 3;
  localparam logic [15:0] COUNT_MAX   = 16'hFFFF;
  localparam logic [15:0] ZERO_WORD   = 16'h0000;
  localparam logic [REC_AW-1:0] PTR_RESET = 3'h0;
  // Display unit codes for the motor speed
  localparam logic [3:0]  UNIT_CENTI  = 4'h0;
  localparam logic [3:0]  UNIT_DECI   = 4'h1;
  localparam logic [3:0]  UNIT_WHOLE  = 4'h2;
  localparam logic [15:0] DIV_DECI    = 16'h000A;
  localparam logic [15:0] DIV_WHOLE   = 16'h0064;
  // Analog: input in mV, level in 0.1 % so 10000 mV reads 1000
  localparam logic [15:0] AN_DIV      = 16'h000A;
  localparam int          AN_NUM      = 3;
endpackage

/* test/dmo_master_model.sv */
`timescale 1ns/1ns
module dmo_master_model
(
  // Clock
  input  wire logic        clk_i,
  // Request
  output logic             req_o,
  output logic             wr_o,
  output logic [15:0]      index_o,
  output logic [7:0]       sub_o,
  output logic [15:0]      wdata_o,
  // Answer
  input  wire logic        ack_i,
  input  wire logic        abort_i,
  input  wire logic [15:0] rdata_i
);
  initial
  begin
    req_o = 1'b0;
    wr_o = 1'b0;
    index_o = 16'h0000;
    sub_o = 8'h00;
    wdata_o = 16'h0000;
  end
  // One access; clear is a write of 00FB to crash sub 0
  task automatic access(input logic w, input logic [15:0] idx,
    input logic [7:0] sb, input logic [15:0] wd,
    output logic ak, output logic ab, output logic [15:0] rd);
    @(posedge clk_i);
    req_o <= 1'b1;
    wr_o <= w;
    index_o <= idx;
    sub_o <= sb;
    wdata_o <= wd;
    @(posedge clk_i);
    req_o <= 1'b0;
    // Released lines carry the inverse, not the last value
    wr_o <= ~w;
    index_o <= ~idx;
    sub_o <= ~sb;
    wdata_o <= ~wd;
    #1;
    ak = ack_i;
    ab = abort_i;
    rd = rdata_i;
  endtask
endmodule // dmo_master_model

/* test/testbench.sv */
`timescale 1ns/1ns
module testbench;
  import dmo_pkg::*;
  logic        clk, rst_n, req, wr, ack, abort, erase, ok, crash, ak, ab;
  logic [15:0] index, wdata, rdata, spd, bus, an1, an2, an3, term, code, rd;
  logic [7:0]  sub;
  logic [3:0]  unit;
  int          fails, n_tests, cycles;
  logic [15:0] idx_t [6] = '{IDX_SPEED, IDX_BUS, IDX_AN1, IDX_AN2, IDX_AN3,
                             IDX_TERM};
  logic [15:0] src_t [6] = '{SRC_SPEED, SRC_BUS, SRC_AN1, SRC_AN2, SRC_AN3,
                             SRC_TERM};
  logic [15:0] spd_t [4] = '{16'h04D2, 16'h007B, 16'h000C, 16'h04D2};

  dmo_monitor_map i_dmo_monitor_map (.CLOCK_I(clk), .RST_N_I(rst_n),
    .REQ_I(req), .WR_I(wr), .INDEX_I(index), .SUB_I(sub), .WDATA_I(wdata),
    .ACK_O(ack), .ABORT_O(abort), .RDATA_O(rdata), .SPEED_RAW_I(spd),
    .SPEED_OK_I(ok), .DISP_UNIT_I(unit), .BUS_VOLT_I(bus), .AN1_MV_I(an1),
    .AN2_MV_I(an2), .AN3_MV_I(an3), .TERM_WORD_I(term), .CRASH_I(crash),
    .CRASH_CODE_I(code), .STORE_ERASE_O(erase));

  dmo_master_model i_dmo_master_model (.clk_i(clk), .req_o(req), .wr_o(wr),
    .index_o(index), .sub_o(sub), .wdata_o(wdata), .ack_i(ack),
    .abort_i(abort), .rdata_i(rdata));

  initial
  begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  task automatic tally_and_finish();
    if (fails == 0 && n_tests > 0)
    begin
      $display("verification passed");
    end
    else
    begin
      $display("verification failed");
    end
    $finish;
  endtask

  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 80000)
    begin
      fails++;
      tally_and_finish();
    end
  end

  task automatic chk1(input logic got, input logic exp);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      fails++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  // One access with expected refusal flag and read word
  task automatic xfer(input logic w, input logic [15:0] idx,
    input logic [7:0] sb, input logic [15:0] wd, input logic eab,
    input logic [15:0] erd);
    i_dmo_master_model.access(w, idx, sb, wd, ak, ab, rd);
    chk1(ak, 1'b1);
    chk1(ab, eab);
    chk16(rd, erd);
  endtask

  initial
  begin
    {rst_n, ok, crash, unit} = '0;
    {spd, bus, an1, an2, an3, term, code} = '0;
    repeat (10) @(posedge clk);
    rst_n <= 1'b1;
    for (int i = 0; i < 6; i++)
    begin
      xfer(0, idx_t[i], SUB_COUNT, 16'h0000, 0, MON_ENTRIES);
      xfer(0, idx_t[i], SUB_SOURCE, 16'h0000, 0, src_t[i]);
    end
    @(posedge clk);
    {ok, spd, bus, term} <= {1'b1, 16'h04D2, 16'h0159, 16'hA5C3};
    {an1, an2, an3} <= {16'h2710, 16'h0005, 16'h3039};
    for (int u = 0; u < 4; u++)
    begin
      @(posedge clk);
      unit <= u[3:0];
      xfer(0, IDX_SPEED, SUB_VALUE, 16'h0000, 0, spd_t[u]);
    end
    @(posedge clk);
    ok <= 1'b0;
    xfer(0, IDX_SPEED, SUB_VALUE, 16'h0000, 0, 16'h0000);
    xfer(0, IDX_BUS, SUB_VALUE, 16'h0000, 0, 16'h0159);
    xfer(0, IDX_AN1, SUB_VALUE, 16'h0000, 0, 16'h03E8);
    xfer(0, IDX_AN2, SUB_VALUE, 16'h0000, 0, 16'h0000);
    xfer(0, IDX_AN3, SUB_VALUE, 16'h0000, 0, 16'h04D2);
    xfer(0, IDX_TERM, SUB_VALUE, 16'h0000, 0, 16'hA5C3);
    xfer(1, IDX_BUS, SUB_VALUE, 16'h1234, 1, 16'h0000);
    xfer(1, IDX_AN1, SUB_SOURCE, 16'h1234, 1, 16'h0000);
    xfer(0, IDX_BUS, SUB_VALUE, 16'h0000, 0, 16'h0159);
    xfer(0, IDX_AN1, SUB_SOURCE, 16'h0000, 0, SRC_AN1);
    xfer(0, 16'h2230, SUB_VALUE, 16'h0000, 1, 16'h0000);
    xfer(0, IDX_TERM, 8'h03, 16'h0000, 1, 16'h0000);
    xfer(0, IDX_CRASH, SUB_COUNT, 16'h0000, 0, CRS_ENTRIES);
    xfer(0, IDX_CRASH, SUB_VALUE, 16'h0000, 0, 16'h0000);
    @(posedge clk);
    {crash, code} <= {1'b1, 16'hBEEF};
    @(posedge clk);
    code <= 16'h1357;
    @(posedge clk);
    crash <= 1'b0;
    xfer(0, IDX_CRASH, SUB_VALUE, 16'h0000, 0, 16'h0002);
    xfer(0, IDX_CRASH, SUB_REC0, 16'h0000, 0, 16'hBEEF);
    xfer(0, IDX_CRASH, 8'h03, 16'h0000, 0, 16'h1357);
    xfer(1, IDX_CRASH, SUB_COUNT, 16'h00FA, 1, 16'h0000);
    chk1(erase, 1'b0);
    xfer(1, IDX_CRASH, SUB_COUNT, 16'h00FB, 0, 16'h0000);
    chk1(erase, 1'b1);
    xfer(0, IDX_CRASH, SUB_VALUE, 16'h0000, 0, 16'h0000);
    xfer(0, IDX_CRASH, SUB_REC0, 16'h0000, 0, 16'h0000);
    xfer(1, IDX_CRASH, SUB_VALUE, 16'h0005, 1, 16'h0000);
    xfer(0, IDX_CRASH, SUB_VALUE, 16'h0000, 0, 16'h0000);
    fork
      xfer(1, IDX_CRASH, SUB_COUNT, 16'h00FB, 0, 16'h0000);
      begin
        @(posedge clk);
        {crash, code} <= {1'b1, 16'h2468};
        @(posedge clk);
        crash <= 1'b0;
      end
    join
    chk1(erase, 1'b1);
    xfer(0, IDX_CRASH, SUB_VALUE, 16'h0000, 0, 16'h0001);
    xfer(0, IDX_CRASH, SUB_REC0, 16'h0000, 0, 16'h2468);
    xfer(0, IDX_CRASH, 8'h03, 16'h0000, 0, 16'h0000);
    @(posedge clk);
    crash <= 1'b1;
    repeat (65540) @(posedge clk);
    crash <= 1'b0;
    xfer(0, IDX_CRASH, SUB_VALUE, 16'h0000, 0, COUNT_MAX);
    tally_and_finish();
  end
endmodule // testbench
